// ===== core/shc_pkg.sv
package shc_pkg;
	// register indexes; byte address is four times the index
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_MODE = 3'h1;
	localparam logic [2:0] IDX_IEN = 3'h2;
	localparam logic [2:0] IDX_FLAG = 3'h3;
	localparam logic [2:0] IDX_DATA = 3'h4;
	localparam logic [1:0] HSIZE_WORD = 2'h2;
	// primary_control fields
	localparam int B_EN = 0;
	localparam int B_PRE = 1;
	localparam int B_DBL = 4;
	localparam int B_HOST = 5;
	localparam int B_ORDER = 6;
	// buffer_and_mode_control fields
	localparam int B_MODE = 0;
	localparam int B_SELDIS = 2;
	localparam int B_WAIT = 6;
	localparam int B_BUF = 7;
	// interrupt_enables fields
	localparam int B_GIE = 0;
	localparam int B_BIE = 4;
	// flag positions, normal and buffer layout
	localparam int B_IF = 7;
	localparam int B_WCOL = 6;
	localparam int B_RXC = 7;
	localparam int B_TXC = 6;
	localparam int B_DRE = 5;
	localparam int B_SSI = 4;
	localparam int B_OVF = 0;
	localparam logic [7:0] CTRL_WMASK = 8'h77;
	localparam logic [7:0] MODE_WMASK = 8'hc7;
	localparam logic [7:0] IEN_WMASK = 8'hf1;
	localparam logic [7:0] REG_RESET = 8'h00;
	// half serial clock periods in peripheral clocks
	localparam logic [6:0] HALF_BY4 = 7'h02;
	localparam logic [6:0] HALF_BY16 = 7'h08;
	localparam logic [6:0] HALF_BY64 = 7'h20;
	localparam logic [6:0] HALF_BY128 = 7'h40;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [3:0] EDGE_LAST = 4'hf;
	localparam logic [1:0] RX_DEPTH = 2'h2;
	typedef enum logic {S_IDLE, S_RUN} shc_state_t;
endpackage

// ===== core/shc_port.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
module shc_port (
	// system
	input wire logic clk,
	input wire logic srst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial pins
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe,
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOe,
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOe,
	input wire logic ssnIn,
	input wire logic ssnIsInput,
	// interrupt
	input wire logic irqAck,
	output logic irq
);
	logic [7:0] ctrl_q, mode_q, ien_q, txSh_q, txBuf_q, rxSh_q, rxData_q, rdVal;
	logic [7:0] rxNext, rxByte;
	logic [7:0] rxBuf_q [2];
	logic [1:0] rxCnt_q, rxLeft, pre;
	logic [6:0] halfCnt_q, halfLen;
	logic [3:0] edgeCnt_q;
	logic [2:0] bitCnt_q, dpIdx_q;
	logic en, host, lsbF, dbl, bufM, waitRx, selDis, cpha, cpol;
	logic take, mapped, dpWr_q, dataWr, dataRd, flagRd, flagWr, dataAcc;
	logic fb, clSel, sckPrev_q, tick, lead, trail, sampleE, doneP, busy, sdi, outNext;
	logic startH, directOk, shLoaded_q, txFull_q, primed_q;
	logic ifF, wcF, ifArm_q, wcArm_q, txcF, dreF, select_trigger_flag, ovfF, setIf, pop, push;
	shc_pkg::shc_state_t state_q;

	function automatic logic bitAt(input logic [7:0] v, input logic [2:0] n, input logic lsb);
		return lsb ? v[n] : v[shc_pkg::BIT_LAST - n];
	endfunction

	assign en = ctrl_q[shc_pkg::B_EN];
	assign host = ctrl_q[shc_pkg::B_HOST];
	assign lsbF = ctrl_q[shc_pkg::B_ORDER];
	assign dbl = ctrl_q[shc_pkg::B_DBL];
	assign pre = ctrl_q[shc_pkg::B_PRE +: 2];
	assign bufM = mode_q[shc_pkg::B_BUF];
	assign waitRx = mode_q[shc_pkg::B_WAIT];
	assign selDis = mode_q[shc_pkg::B_SELDIS];
	assign cpha = mode_q[shc_pkg::B_MODE];
	assign cpol = mode_q[shc_pkg::B_MODE + 1];

	// bus decode; reads are sampled in the address phase so hrdata is a flop
	assign take = hsel && htrans[1] && hready;
	assign mapped = haddr[31:2] <= {27'h0, shc_pkg::IDX_DATA} && haddr[1:0] == 2'h0
		&& hsize[1:0] == shc_pkg::HSIZE_WORD;
	assign dataWr = dpWr_q && dpIdx_q == shc_pkg::IDX_DATA;
	assign flagWr = dpWr_q && dpIdx_q == shc_pkg::IDX_FLAG && bufM;
	assign dataRd = take && !hwrite && mapped && haddr[4:2] == shc_pkg::IDX_DATA;
	assign flagRd = take && !hwrite && mapped && haddr[4:2] == shc_pkg::IDX_FLAG;
	assign dataAcc = dataWr || dataRd;

	always_comb begin
		unique case (haddr[4:2])
			shc_pkg::IDX_CTRL: rdVal = ctrl_q;
			shc_pkg::IDX_MODE: rdVal = mode_q;
			shc_pkg::IDX_IEN: rdVal = bufM ? ien_q : {7'h00, ien_q[shc_pkg::B_GIE]};
			shc_pkg::IDX_FLAG: rdVal = bufM ? {rxCnt_q != 2'h0, txcF, dreF, select_trigger_flag, 3'h0, ovfF}
				: {ifF, wcF, 6'h00};
			shc_pkg::IDX_DATA: rdVal = bufM ? rxBuf_q[0] : rxData_q;
			default: rdVal = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dpWr_q <= 1'b0;
			dpIdx_q <= 3'h0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			dpWr_q <= take && hwrite && mapped;
			dpIdx_q <= haddr[4:2];
			if (take && !hwrite) begin
				hrdata <= {24'h0, mapped ? rdVal : 8'h00};
			end
		end
	end

	// control registers
	assign fb = en && host && ssnIsInput && !selDis && !ssnIn;
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= shc_pkg::REG_RESET;
			mode_q <= shc_pkg::REG_RESET;
			ien_q <= shc_pkg::REG_RESET;
		end else begin
			if (dpWr_q && dpIdx_q == shc_pkg::IDX_CTRL) begin
				ctrl_q <= hwdata[7:0] & shc_pkg::CTRL_WMASK;
			end
			if (dpWr_q && dpIdx_q == shc_pkg::IDX_MODE) begin
				mode_q <= hwdata[7:0] & shc_pkg::MODE_WMASK;
			end
			if (dpWr_q && dpIdx_q == shc_pkg::IDX_IEN) begin
				ien_q <= hwdata[7:0] & shc_pkg::IEN_WMASK;
			end
			// the pin wins over a software write of host-select in the same cycle
			if (fb) begin
				ctrl_q[shc_pkg::B_HOST] <= 1'b0;
			end
		end
	end

	// host serial clock generator
	always_comb begin
		unique case (pre)
			2'h0: halfLen = shc_pkg::HALF_BY4;
			2'h1: halfLen = shc_pkg::HALF_BY16;
			2'h2: halfLen = shc_pkg::HALF_BY64;
			2'h3: halfLen = shc_pkg::HALF_BY128;
		endcase
		if (dbl) begin
			halfLen = halfLen >> 1;
		end
	end

	assign tick = state_q == shc_pkg::S_RUN && halfCnt_q == halfLen - 7'h1;
	assign startH = en && host && !fb && state_q == shc_pkg::S_IDLE
		&& (shLoaded_q || (bufM && txFull_q));
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= shc_pkg::S_IDLE;
			halfCnt_q <= 7'h0;
			edgeCnt_q <= 4'h0;
			sckOut <= 1'b0;
			sckOe <= 1'b0;
			mosiOe <= 1'b0;
			misoOe <= 1'b0;
		end else begin
			sckOe <= en && host;
			mosiOe <= en && host;
			misoOe <= en && !host && !ssnIn;
			if (!en || !host || fb) begin
				state_q <= shc_pkg::S_IDLE;
				sckOut <= cpol;
			end else begin
				unique case (state_q)
					shc_pkg::S_IDLE: begin
						sckOut <= cpol;
						halfCnt_q <= 7'h0;
						edgeCnt_q <= 4'h0;
						if (startH) begin
							state_q <= shc_pkg::S_RUN;
						end
					end
					shc_pkg::S_RUN: begin
						halfCnt_q <= tick ? 7'h0 : halfCnt_q + 7'h1;
						if (tick) begin
							sckOut <= !sckOut;
							edgeCnt_q <= edgeCnt_q + 4'h1;
							if (edgeCnt_q == shc_pkg::EDGE_LAST) begin
								state_q <= shc_pkg::S_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	// edge events common to host and client; pins are already synchronous
	assign clSel = en && !host && !ssnIn;
	assign lead = host ? tick && !edgeCnt_q[0]
		: clSel && (cpol ? (sckPrev_q && !sckIn) : (sckIn && !sckPrev_q));
	assign trail = host ? tick && edgeCnt_q[0]
		: clSel && (cpol ? (sckIn && !sckPrev_q) : (sckPrev_q && !sckIn));
	assign sampleE = cpha ? trail : lead;
	assign doneP = trail && bitCnt_q == shc_pkg::BIT_LAST;
	assign busy = state_q == shc_pkg::S_RUN || bitCnt_q != 3'h0;
	assign sdi = host ? misoIn : mosiIn;
	assign rxNext = lsbF ? {sdi, rxSh_q[7:1]} : {rxSh_q[6:0], sdi};
	assign rxByte = sampleE ? rxNext : rxSh_q;

	always_comb begin
		outNext = mosiOut;
		if (cpha && lead) begin
			outNext = bitAt(txSh_q, bitCnt_q, lsbF);
		end else if (!cpha && trail) begin
			outNext = bitAt(txSh_q, bitCnt_q + 3'h1, lsbF);
		end else if (!cpha && bitCnt_q == 3'h0) begin
			outNext = bitAt(txSh_q, 3'h0, lsbF);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sckPrev_q <= 1'b0;
			rxSh_q <= 8'h00;
			bitCnt_q <= 3'h0;
			mosiOut <= 1'b0;
			misoOut <= 1'b0;
		end else begin
			sckPrev_q <= sckIn;
			mosiOut <= outNext;
			misoOut <= outNext;
			if (sampleE) begin
				rxSh_q <= rxNext;
			end
			if (!en || fb || (!host && !clSel)) begin
				bitCnt_q <= 3'h0;
			end else if (trail) begin
				bitCnt_q <= bitCnt_q + 3'h1;
			end
		end
	end

	// transmit path
	assign directOk = bufM && waitRx && !primed_q && ssnIn && !busy && !shLoaded_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			txSh_q <= 8'h00;
			txBuf_q <= 8'h00;
			shLoaded_q <= 1'b0;
			txFull_q <= 1'b0;
			primed_q <= 1'b0;
			dreF <= 1'b0;
		end else if (!en) begin
			shLoaded_q <= 1'b0;
			primed_q <= 1'b0;
		end else begin
			if ((dataWr && bufM) || (flagWr && hwdata[shc_pkg::B_DRE])) begin
				dreF <= 1'b0;
			end
			if (dataWr && !bufM && !busy) begin
				txSh_q <= hwdata[7:0];
				shLoaded_q <= 1'b1;
			end
			if (dataWr && bufM) begin
				if (directOk) begin
					txSh_q <= hwdata[7:0];
					shLoaded_q <= 1'b1;
					primed_q <= 1'b1;
				end else if (!txFull_q) begin
					txBuf_q <= hwdata[7:0];
					txFull_q <= 1'b1;
				end
			end
			if (startH && !shLoaded_q) begin
				primed_q <= 1'b1;
				if (!waitRx && !primed_q) begin
					txSh_q <= 8'h00;
				end else begin
					txSh_q <= txBuf_q;
					txFull_q <= 1'b0;
					dreF <= 1'b1;
				end
			end
			if (doneP) begin
				shLoaded_q <= 1'b0;
				primed_q <= 1'b1;
				if (bufM && txFull_q) begin
					txSh_q <= txBuf_q;
					shLoaded_q <= 1'b1;
					txFull_q <= 1'b0;
					dreF <= 1'b1;
				end
			end
		end
	end

	// receive path; a full pair of buffers drops the third byte
	assign pop = dataRd && bufM && rxCnt_q != 2'h0;
	assign push = doneP && bufM;
	assign rxLeft = rxCnt_q - {1'b0, pop};
	always_ff @(posedge clk) begin
		if (srst) begin
			rxData_q <= 8'h00;
			rxBuf_q[0] <= 8'h00;
			rxBuf_q[1] <= 8'h00;
			rxCnt_q <= 2'h0;
			ovfF <= 1'b0;
		end else begin
			if (doneP && !bufM) begin
				rxData_q <= rxByte;
			end
			if (pop) begin
				rxBuf_q[0] <= rxBuf_q[1];
			end
			if (dataRd || (flagWr && hwdata[shc_pkg::B_OVF])) begin
				ovfF <= 1'b0;
			end
			if (push && rxLeft != shc_pkg::RX_DEPTH) begin
				rxBuf_q[rxLeft[0]] <= rxByte;
			end
			if (push && rxLeft == shc_pkg::RX_DEPTH) begin
				ovfF <= 1'b1;
			end
			rxCnt_q <= rxLeft + {1'b0, push && rxLeft != shc_pkg::RX_DEPTH};
		end
	end

	// flags: a set in the same cycle as a clear always wins
	assign setIf = (doneP && !bufM) || fb;
	always_ff @(posedge clk) begin
		if (srst) begin
			ifF <= 1'b0;
			wcF <= 1'b0;
			ifArm_q <= 1'b0;
			wcArm_q <= 1'b0;
			txcF <= 1'b0;
			select_trigger_flag <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (flagRd) begin
				ifArm_q <= ifF;
				wcArm_q <= wcF;
			end else if (dataAcc) begin
				ifArm_q <= 1'b0;
				wcArm_q <= 1'b0;
			end
			if (irqAck || (ifArm_q && dataAcc)) begin
				ifF <= 1'b0;
			end
			if (setIf) begin
				ifF <= 1'b1;
			end
			if (wcArm_q && dataAcc) begin
				wcF <= 1'b0;
			end
			if (dataWr && !bufM && busy) begin
				wcF <= 1'b1;
			end
			if (flagWr && hwdata[shc_pkg::B_TXC]) begin
				txcF <= 1'b0;
			end
			if (push && !txFull_q) begin
				txcF <= 1'b1;
			end
			if (flagWr && hwdata[shc_pkg::B_SSI]) begin
				select_trigger_flag <= 1'b0;
			end
			if (fb && bufM) begin
				select_trigger_flag <= 1'b1;
			end
			irq <= bufM ? |(ien_q[shc_pkg::B_BIE +: 4] & {rxCnt_q != 2'h0, txcF, dreF, select_trigger_flag})
				: ien_q[shc_pkg::B_GIE] && ifF;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	property p_fallback;
		fb |=> !host && ifF;
	endproperty
	a_fallback: assert property (p_fallback) else $error("fallback did not drop host");
	property p_selDis;
		en && host && selDis && !ssnIn && !(dpWr_q && dpIdx_q == shc_pkg::IDX_CTRL) |=> host;
	endproperty
	a_selDis: assert property (p_selDis) else $error("host lost with select disabled");
	property p_dbl;
		host && state_q == shc_pkg::S_RUN && pre == 2'h0 && dbl && tick |=>
			state_q == shc_pkg::S_IDLE || tick;
	endproperty
	a_dbl: assert property (p_dbl) else $error("doubled clock not every cycle");
	property p_len;
		startH && pre == 2'h0 && !dbl |=> state_q == shc_pkg::S_RUN ##31
			state_q == shc_pkg::S_RUN ##1 state_q == shc_pkg::S_IDLE;
	endproperty
	a_len: assert property (p_len) else $error("byte length wrong at divide by 4");
	property p_idle;
		state_q == shc_pkg::S_IDLE && $past(state_q) == shc_pkg::S_IDLE && $stable(mode_q)
			|-> sckOut == cpol;
	endproperty
	a_idle: assert property (p_idle) else $error("clock idle level wrong");
	property p_first;
		host && state_q == shc_pkg::S_RUN && edgeCnt_q == 4'h1 && !cpha
			|-> mosiOut == (lsbF ? txSh_q[0] : txSh_q[7]);
	endproperty
	a_first: assert property (p_first) else $error("first bit order wrong");
	property p_off;
		!en |=> state_q == shc_pkg::S_IDLE && !sckOe && !misoOe;
	endproperty
	a_off: assert property (p_off) else $error("active while disabled");
	property p_wcol;
		dataWr && !bufM && busy |=> wcF && txSh_q == $past(txSh_q);
	endproperty
	a_wcol: assert property (p_wcol) else $error("collision not flagged");
	property p_ack;
		irqAck && !setIf |=> !ifF;
	endproperty
	a_ack: assert property (p_ack) else $error("ack did not clear flag");
	property p_irq;
		!bufM && ien_q[shc_pkg::B_GIE] && ifF |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
	property p_noirq;
		!bufM && !ifF |=> !irq;
	endproperty
	a_noirq: assert property (p_noirq) else $error("irq without flag");
	property p_abort;
		en && !host && ssnIn |=> bitCnt_q == 3'h0;
	endproperty
	a_abort: assert property (p_abort) else $error("client not reset by select");
	property p_dummy;
		startH && bufM && !waitRx && !primed_q && !shLoaded_q |=> txSh_q == 8'h00;
	endproperty
	a_dummy: assert property (p_dummy) else $error("no dummy word");
	property p_direct;
		dataWr && en && directOk |=> shLoaded_q && txSh_q == $past(hwdata[7:0]);
	endproperty
	a_direct: assert property (p_direct) else $error("direct load missed");

	c_hostByte: cover property (startH ##1 state_q == shc_pkg::S_RUN [*8]);
	c_client: cover property (!host && doneP);
	c_fallback: cover property (fb);
	c_overflow: cover property (push && rxLeft == shc_pkg::RX_DEPTH);
endmodule

// ===== test/shc_far_model.sv
`timescale 1ns/100ps
module shc_far_model (
	// bench clock and serial lines
	input wire logic clk,
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// bench settings
	input wire logic [1:0] mode,
	input wire logic lsbFirst,
	input wire logic active,
	input wire logic [7:0] txByte,
	output logic [7:0] rxByte
);
	logic sckQ;
	logic idle = 1'b0;
	logic [3:0] setups = 4'h0;
	logic [2:0] k;
	// released line keeps moving so a stale bit never passes for data
	always @(posedge clk) idle = ~idle;
	// with setup on the leading edge the first edge only presents bit 0
	assign k = (mode[0] && setups != 4'h0) ? 3'(setups - 4'h1) : setups[2:0];
	assign miso = active ? txByte[lsbFirst ? k : 3'h7 - k] : idle;
	always @(sck or active) begin
		if (!active) begin
			setups = 4'h0;
		end else if (sck !== sckQ) begin
			if ((sck !== mode[1]) == mode[0]) begin
				setups = setups + 4'h1;
			end else begin
				rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
			end
		end
		sckQ = sck;
	end
endmodule

// ===== test/testbench.sv
`timescale 1ns/100ps
module testbench;
	localparam logic [31:0] A_CTRL = {27'h0, shc_pkg::IDX_CTRL, 2'h0};
	localparam logic [31:0] A_MODE = {27'h0, shc_pkg::IDX_MODE, 2'h0};
	localparam logic [31:0] A_IEN = {27'h0, shc_pkg::IDX_IEN, 2'h0};
	localparam logic [31:0] A_FLAG = {27'h0, shc_pkg::IDX_FLAG, 2'h0};
	localparam logic [31:0] A_DATA = {27'h0, shc_pkg::IDX_DATA, 2'h0};
	logic clk, srst, hsel, hwrite, sckIn, mosiIn, ssnIn, ssnIsInput, irqAck;
	logic hreadyout, sckOut, sckOe, mosiOut, farMiso, irq, active, farLsb;
	logic hresp, mosiOe, misoOut, misoOe;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, farMode;
	logic [2:0] hsize;
	logic [7:0] farTx, farRx;
	int errCount, samplesChecked;
	shc_port uut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sckIn(sckIn),
		.sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiIn), .mosiOut(mosiOut),
		.mosiOe(mosiOe), .misoIn(farMiso), .misoOut(misoOut), .misoOe(misoOe),
		.ssnIn(ssnIn), .ssnIsInput(ssnIsInput), .irqAck(irqAck),
		.irq(irq));
	shc_far_model far (.clk(clk), .sck(sckOut), .mosi(mosiOut), .miso(farMiso),
		.mode(farMode), .lsbFirst(farLsb), .active(active), .txByte(farTx), .rxByte(farRx));
	always #12.5 clk = ~clk;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samplesChecked, errCount);
		if (errCount == 0 && samplesChecked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d,
		output logic [31:0] q);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 8'h00, q);
		cmp(q, e);
	endtask
	// polling re-arms the flag clear, which the callers rely on
	task automatic waitf(input int b);
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			acc(1'b0, A_FLAG, 8'h00, q);
			n++;
		end while (q[b] !== 1'b1 && n < 600);
		cmp(32'(q[b]), 32'h1);
	endtask
	task automatic fresh(input logic [7:0] f);
		farTx <= f;
		active <= 1'b0;
		@(posedge clk);
		active <= 1'b1;
	endtask
	task automatic xfer(input logic [7:0] d, input logic [7:0] f);
		fresh(f);
		wr(A_DATA, d);
		waitf(7);
		rd(A_FLAG, 32'h80);
		cmp(32'(farRx), 32'(d));
		rd(A_DATA, 32'(f));
		rd(A_FLAG, 32'h0);
	endtask
	task automatic half(input logic [31:0] e);
		logic s;
		int c;
		c = 0;
		s = sckOut;
		while (sckOut === s) @(posedge clk);
		s = sckOut;
		while (sckOut === s) begin
			@(posedge clk);
			c++;
		end
		cmp(32'(c), e);
	endtask
	task automatic cbit(input logic b, output logic so);
		mosiIn <= b;
		repeat (4) @(posedge clk);
		so = misoOut;
		sckIn <= 1'b1;
		repeat (4) @(posedge clk);
		sckIn <= 1'b0;
	endtask
	initial begin
		int i, m, o;
		logic [31:0] q;
		logic [31:0] adr [3];
		logic [31:0] msk [3];
		logic [6:0] hv [4];
		clk = 1'b0;
		srst = 1'b1;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = {1'b0, shc_pkg::HSIZE_WORD};
		hwdata = 32'h0;
		sckIn = 1'b0;
		mosiIn = 1'b0;
		ssnIn = 1'b1;
		ssnIsInput = 1'b0;
		irqAck = 1'b0;
		active = 1'b0;
		farTx = 8'h00;
		farMode = 2'h0;
		farLsb = 1'b0;
		errCount = 0;
		samplesChecked = 0;
		adr = '{A_CTRL, A_MODE, A_IEN};
		msk = '{32'h77, 32'hc7, 32'h01};
		hv = '{shc_pkg::HALF_BY4, shc_pkg::HALF_BY16, shc_pkg::HALF_BY64,
			shc_pkg::HALF_BY128};
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		for (i = 0; i < 5; i++) rd(32'(i * 4), 32'h0);
		for (i = 0; i < 3; i++) begin
			wr(adr[i], 8'hff);
			rd(adr[i], msk[i]);
			wr(adr[i], 8'h00);
		end
		wr(32'h14, 8'hff);
		rd(32'h14, 32'h0);
		cmp(32'(hresp), 32'h0);
		$display("test registers done");
		for (m = 0; m < 4; m++) begin
			for (o = 0; o < 2; o++) begin
				farMode <= 2'(m);
				farLsb <= 1'(o);
				wr(A_MODE, 8'(m));
				wr(A_CTRL, 8'(8'h21 | (o << 6)));
				// output enables follow the control write by one registered cycle
				repeat (2) @(posedge clk);
				cmp(32'(sckOe), 32'h1);
				cmp(32'(mosiOe), 32'h1);
				cmp(32'(sckOut), 32'(m >> 1));
				xfer(8'(8'h1d + m * 40 + o), 8'(8'hb2 - m * 24 - o));
			end
		end
		$display("test modes done");
		wr(A_MODE, 8'h00);
		farMode <= 2'h0;
		farLsb <= 1'b0;
		for (m = 0; m < 8; m++) begin
			wr(A_CTRL, 8'(8'h21 | ((m % 4) << 1) | ((m / 4) << 4)));
			fork
				xfer(8'(8'h61 + m), 8'(8'h9e - m));
				half(32'(hv[m % 4] >> (m / 4)));
			join
		end
		$display("test rates done");
		wr(A_IEN, 8'h01);
		wr(A_CTRL, 8'h27);
		fresh(8'h00);
		wr(A_DATA, 8'h3c);
		wr(A_DATA, 8'h99);
		rd(A_FLAG, 32'h40);
		acc(1'b0, A_DATA, 8'h00, q);
		rd(A_FLAG, 32'h0);
		i = 0;
		while (irq !== 1'b1 && i < 2000) begin
			@(posedge clk);
			i++;
		end
		repeat (4) @(posedge clk);
		cmp(32'(irq), 32'h1);
		cmp(32'(farRx), 32'h3c);
		irqAck <= 1'b1;
		@(posedge clk);
		irqAck <= 1'b0;
		repeat (2) @(posedge clk);
		cmp(32'(irq), 32'h0);
		rd(A_FLAG, 32'h0);
		wr(A_CTRL, 8'h20);
		wr(A_DATA, 8'h55);
		repeat (40) @(posedge clk);
		cmp(32'(sckOe), 32'h0);
		rd(A_FLAG, 32'h0);
		$display("test collision done");
		ssnIsInput <= 1'b1;
		wr(A_CTRL, 8'h21);
		ssnIn <= 1'b0;
		repeat (3) @(posedge clk);
		rd(A_CTRL, 32'h01);
		rd(A_FLAG, 32'h80);
		cmp(32'(irq), 32'h1);
		acc(1'b0, A_DATA, 8'h00, q);
		ssnIn <= 1'b1;
		wr(A_MODE, 8'h04);
		wr(A_CTRL, 8'h21);
		ssnIn <= 1'b0;
		repeat (3) @(posedge clk);
		rd(A_CTRL, 32'h21);
		rd(A_FLAG, 32'h0);
		ssnIn <= 1'b1;
		ssnIsInput <= 1'b0;
		$display("test fallback done");
		wr(A_CTRL, 8'h00);
		wr(A_MODE, 8'h80);
		wr(A_IEN, 8'hf1);
		rd(A_IEN, 32'hf1);
		wr(A_CTRL, 8'h27);
		fresh(8'hc3);
		wr(A_DATA, 8'h5a);
		waitf(7);
		cmp(32'(farRx), 32'h0);
		waitf(6);
		cmp(32'(farRx), 32'h5a);
		rd(A_DATA, 32'hc3);
		rd(A_DATA, 32'hc3);
		rd(A_FLAG, 32'h60);
		wr(A_FLAG, 8'h60);
		wr(A_CTRL, 8'h00);
		wr(A_MODE, 8'hc0);
		wr(A_CTRL, 8'h27);
		fresh(8'h00);
		wr(A_DATA, 8'ha7);
		waitf(6);
		cmp(32'(farRx), 32'ha7);
		cmp(32'(irq), 32'h1);
		$display("test buffer done");
		wr(A_CTRL, 8'h00);
		wr(A_MODE, 8'h00);
		wr(A_IEN, 8'h00);
		wr(A_CTRL, 8'h01);
		ssnIn <= 1'b0;
		for (i = 0; i < 3; i++) cbit(1'b1, q[0]);
		ssnIn <= 1'b1;
		repeat (4) @(posedge clk);
		wr(A_DATA, 8'h3c);
		q = 32'h0;
		ssnIn <= 1'b0;
		for (i = 7; i >= 0; i--) cbit(1'(8'ha5 >> i), q[i]);
		repeat (4) @(posedge clk);
		cmp(32'(misoOe), 32'h1);
		cmp(q, 32'h3c);
		ssnIn <= 1'b1;
		rd(A_FLAG, 32'h80);
		rd(A_DATA, 32'ha5);
		$display("test client done");
		stop_test();
	end
	// whole run is well under ten thousand cycles
	initial begin
		repeat (60000) @(posedge clk);
		errCount++;
		stop_test();
	end
endmodule
